// ---- gate_driver_model.sv ----
// Model of the six gate drivers: counts on-cycles per output and sync
// pulses inside a window. Assumes active-low gate signals on clk.
`timescale 1ns/10ps
`default_nettype none
module gate_driver_model (
   input wire logic clk,
   input wire logic window,
   input wire logic clear,
   input wire logic [5:0] gate_n,
   input wire logic sync_pulse,
   output logic [7:0] on_cnt [6],
   output logic [7:0] sync_cnt
);
   // Tally on-time per device and sync pulses
   always_ff @(posedge clk) begin
      for (int k = 0; k < 6; k++) begin
         if (clear)
            on_cnt[k] <= 8'h00;
         else if (window && !gate_n[k])
            on_cnt[k] <= on_cnt[k] + 8'h01; // Low level turns device on
      end
      if (clear)
         sync_cnt <= 8'h00;
      else if (window && sync_pulse)
         sync_cnt <= sync_cnt + 8'h01;
   end
endmodule
`default_nettype wire

// ---- phase_timing.sv ----
// One phase of the timing unit: center-based active-low pair with dead
// time, narrow-pulse deletion and reluctance hold. Purely combinational.
// Assumes the core supplies latched working values and the half count.
`timescale 1ns/10ps
`default_nettype none
module phase_timing (
   phase_timing_if.slice pt
);
   import pwm_out_pkg::*;

   logic [COUNT_W-1:0] hi_on;
   logic [COUNT_W-1:0] lo_on;
   logic [COUNT_W-1:0] dead_ext;
   logic [COUNT_W-1:0] min_ext;
   logic hi_raw;
   logic lo_raw;

   // On-times per half, both edges moved by the dead time
   always_comb begin
      dead_ext = {{(COUNT_W-DEAD_W){1'b0}}, pt.dead_time};
      min_ext = {{(COUNT_W-MIN_W){1'b0}}, pt.min_on_time};
      hi_on = sat_sub((pt.duty > pt.half_len) ? pt.half_len : pt.duty, dead_ext);
      lo_on = sat_sub(sat_sub(pt.half_len, pt.duty), dead_ext);
   end

   // Centered placement: high side on late in first half, early in second; low side the reverse
   always_comb begin
      if (pt.second_half) begin
         hi_raw = pt.count < hi_on;
         lo_raw = pt.count >= sat_sub(pt.half_len, lo_on);
      end else begin
         hi_raw = pt.count >= sat_sub(pt.half_len, hi_on);
         lo_raw = pt.count < lo_on;
      end
   end

   // Deletion of short pulses, reluctance hold, active-low drive
   always_comb begin
      pt.hi_n = ~hi_raw;
      pt.lo_n = ~lo_raw;
      if (hi_on < min_ext) begin
         pt.hi_n = 1'b1;
         pt.lo_n = 1'b0;
      end else if (lo_on < min_ext) begin
         pt.lo_n = 1'b1;
         pt.hi_n = 1'b0;
      end
      if (pt.reluctance_mode) begin
         pt.lo_n = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- phase_timing_if.sv ----
// Carrier between the core and one phase timing slice.
// Assumes one instance per phase, all on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface phase_timing_if;
   import pwm_out_pkg::*;
   logic [COUNT_W-1:0] half_len;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] duty;
   logic [DEAD_W-1:0] dead_time;
   logic [MIN_W-1:0] min_on_time;
   logic second_half;
   logic reluctance_mode;
   logic hi_n;
   logic lo_n;

   modport core (output half_len, count, duty, dead_time, min_on_time, second_half, reluctance_mode,
                 input hi_n, lo_n);
   modport slice (input half_len, count, duty, dead_time, min_on_time, second_half, reluctance_mode,
                  output hi_n, lo_n);
endinterface
`default_nettype wire

// ---- pin_sync.sv ----
// Three-flop synchroniser for a slow pin, with agreement of the last two.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic pin,
   output logic level
);
   import pwm_out_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] chain;
      logic level;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   // Shift chain; level moves once stages two and three agree
   always_comb begin
      next_state = state;
      next_state.chain = {state.chain[SYNC_STAGES-2:0], pin};
      if (state.chain[1] == state.chain[2]) begin
         next_state.level = state.chain[2];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= '{chain: {SYNC_STAGES{RESET_LEVEL}}, level: RESET_LEVEL};
      end else begin
         state <= next_state;
      end
   end

   assign level = state.level;
endmodule
`default_nettype wire

// ---- pwm_out_checker.sv ----
// Checker on the PWM back end top ports: bus handshake, reset state,
// disables, reluctance hold, status mirror. Assumes one clock domain.
`timescale 1ns/10ps
`default_nettype none
module pwm_out_checker (
   input wire logic clk,
   input wire logic srst,
   input wire logic [pwm_out_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic reluctance_select_n,
   input wire logic out_a_high,
   input wire logic out_a_low,
   input wire logic out_b_high,
   input wire logic out_b_low,
   input wire logic out_c_high,
   input wire logic out_c_low,
   input wire logic period_sync_pulse
);
   import pwm_out_pkg::*;
   logic [8:0] shadow;
   logic [1:0] quiet;
   logic [3:0] pin_age;
   logic pin_last;
   logic wr_done;
   logic [2:0] dis_hi;
   logic [2:0] dis_lo;
   // Completed write, disable fields of last steering value
   assign wr_done = avs_write && !avs_waitrequest;
   assign dis_hi = {shadow[DIS_A_HIGH_BIT], shadow[DIS_B_HIGH_BIT], shadow[DIS_C_HIGH_BIT]};
   assign dis_lo = {shadow[DIS_A_LOW_BIT], shadow[DIS_B_LOW_BIT], shadow[DIS_C_LOW_BIT]};
   // Steering copy, syncs since last change, pin stable age
   always_ff @(posedge clk) begin
      if (srst) begin
         shadow <= STEER_RESET;
         quiet <= 2'h0;
         pin_age <= 4'h0;
      end else begin
         if (wr_done && avs_address == OFS_OUTPUT_STEERING)
            shadow <= avs_writedata[8:0];
         if (wr_done || reluctance_select_n != pin_last)
            quiet <= 2'h0;
         else if (period_sync_pulse && quiet != 2'h3)
            quiet <= quiet + 2'h1;
         if (reluctance_select_n != pin_last)
            pin_age <= 4'h0;
         else if (pin_age != 4'hF)
            pin_age <= pin_age + 4'h1;
      end
      pin_last <= reluctance_select_n;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");
   wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   reset_idle_a: assert property ($fell(srst) |-> avs_waitrequest && avs_readdata == 32'h0 &&
      {out_a_high, out_a_low, out_b_high, out_b_low, out_c_high, out_c_low} == 6'h3F && !period_sync_pulse)
      else $error("outputs not idle after reset");
   sync_single_a: assert property (period_sync_pulse |=> !period_sync_pulse)
      else $error("sync pulse longer than one cycle");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h24 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   status_pin_a: assert property (avs_read && !avs_waitrequest && avs_address == OFS_SYSTEM_STATUS &&
      pin_age >= 4'h8 |-> avs_readdata[STAT_RELUCT_BIT] == reluctance_select_n)
      else $error("status bit does not mirror pin");
   high_disable_a: assert property (quiet == 2'h3 |->
      ({out_a_high, out_b_high, out_c_high} & dis_hi) == dis_hi)
      else $error("disabled high output driven on");
   low_disable_a: assert property (quiet == 2'h3 |->
      ({out_a_low, out_b_low, out_c_low} & dis_lo) == dis_lo)
      else $error("disabled low output driven on");
   reluct_hold_a: assert property (quiet == 2'h3 && !reluctance_select_n && shadow[8:6] == 3'h0 |->
      {out_a_low, out_b_low, out_c_low} == dis_lo)
      else $error("low side not held on in reluctance mode");
endmodule
bind pwm_pulse_delete_output_ctrl pwm_out_checker chk (.clk, .srst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .reluctance_select_n, .out_a_high, .out_a_low,
   .out_b_high, .out_b_low, .out_c_high, .out_c_low, .period_sync_pulse);
`default_nettype wire

// ---- pwm_out_pkg.sv ----
// Shared constants for the pulse-delete and output-steering PWM back end.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package pwm_out_pkg;

   // Data widths
   localparam int COUNT_W = 16;
   localparam int DEAD_W = 10;
   localparam int MIN_W = 10;
   localparam int STEER_W = 9;
   localparam int ADDR_W = 6;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_HALF_PERIOD = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_DUTY_A = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_DUTY_B = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_DUTY_C = 6'h14;
   localparam logic [ADDR_W-1:0] OFS_MIN_ON_TIME = 6'h18;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT_STEERING = 6'h1C;
   localparam logic [ADDR_W-1:0] OFS_SYSTEM_STATUS = 6'h20;

   // Control register fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_DOUBLE_BIT = 1;

   // Status register fields
   localparam int STAT_HALF_BIT = 3;
   localparam int STAT_RELUCT_BIT = 4;

   // Output steering fields: crossover per phase, disables per pin
   localparam int XOVER_A_BIT = 8;
   localparam int XOVER_B_BIT = 7;
   localparam int XOVER_C_BIT = 6;
   localparam int DIS_A_LOW_BIT = 5;
   localparam int DIS_A_HIGH_BIT = 4;
   localparam int DIS_B_LOW_BIT = 3;
   localparam int DIS_B_HIGH_BIT = 2;
   localparam int DIS_C_LOW_BIT = 1;
   localparam int DIS_C_HIGH_BIT = 0;

   // Reset values
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
   localparam logic [DEAD_W-1:0] DEAD_RESET = 10'h000;
   localparam logic [MIN_W-1:0] MIN_RESET = 10'h000;
   localparam logic [STEER_W-1:0] STEER_RESET = 9'h000;

   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;

   // Saturating subtraction of on-time terms
   function automatic logic [COUNT_W-1:0] sat_sub(input logic [COUNT_W-1:0] a, input logic [COUNT_W-1:0] b);
      sat_sub = (a > b) ? (a - b) : COUNT_RESET;
   endfunction

endpackage

// ---- pwm_pulse_delete_output_ctrl.sv ----
// Notes on behaviour
// - Single update: same duty in both halves
// - Double update: separate duty per half
// - Ten-bit minimum on-time in clock periods
// - Short pulse off, complement fully on
// - Reluctance pin low holds low sides on
// - High sides still follow duty in reluctance
// - Reluctance only from pin, high disables
// - Status bit 4 shows reluctance pin
// - Crossover enables in bits 8,7,6
// - Crossover swaps high and low signals
// - Reset clears crossover bits
// - Bits 5..0 disable low, high per phase
// - Disabled output held off
// - Disables applied after crossover
// - Reset clears all disable bits
// - Steering latched at period start, and midpoint when double
// - Duty is high-side on-time per half
// - Timing signals are active low
// - Dead time moves both edges equally
// - Double update adds midpoint sync pulse
//
// Top of the PWM back end: Avalon-MM register slave, half-period counter,
// working-copy latch, three phase slices and the output control stage.
// Assumes reluctance_select_n comes from a pin with a pull-up outside.
`timescale 1ns/10ps
`default_nettype none
module pwm_pulse_delete_output_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic [pwm_out_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic reluctance_select_n,
   output logic out_a_high,
   output logic out_a_low,
   output logic out_b_high,
   output logic out_b_low,
   output logic out_c_high,
   output logic out_c_low,
   output logic period_sync_pulse
);
   import pwm_out_pkg::*;

   // Software copies and working copies live in one state record
   typedef struct packed {
      logic [1:0] control;
      logic [COUNT_W-1:0] half_period_count;
      logic [DEAD_W-1:0] dead_time;
      logic [COUNT_W-1:0] duty_phase_a;
      logic [COUNT_W-1:0] duty_phase_b;
      logic [COUNT_W-1:0] duty_phase_c;
      logic [MIN_W-1:0] min_on_time;
      logic [STEER_W-1:0] output_steering;
      logic double_w;
      logic [COUNT_W-1:0] half_len_w;
      logic [DEAD_W-1:0] dead_w;
      logic [COUNT_W-1:0] duty_a_w;
      logic [COUNT_W-1:0] duty_b_w;
      logic [COUNT_W-1:0] duty_c_w;
      logic [MIN_W-1:0] min_w;
      logic [STEER_W-1:0] steer_w;
      logic running;
      logic second_half;
      logic [COUNT_W-1:0] count;
      logic [31:0] readdata;
      logic waitrequest;
      logic [5:0] outs;
      logic sync_pulse;
   } core_state_t;

   core_state_t state;
   core_state_t next_state;
   logic reluctance_level;
   logic reluctance_mode;
   logic bus_req;
   logic bus_take;
   logic at_half_end;
   logic latch_now;
   logic [2:0] timing_hi_n;
   logic [2:0] timing_lo_n;
   logic [5:0] crossed;
   logic [5:0] gated;

   phase_timing_if phase_a_if ();
   phase_timing_if phase_b_if ();
   phase_timing_if phase_c_if ();

   // Reluctance select pin, pulled high outside so idle means off
   pin_sync #(
      .RESET_LEVEL(1'b1)
   ) reluct_sync (
      .clk(clk),
      .srst(srst),
      .pin(reluctance_select_n),
      .level(reluctance_level)
   );

   assign reluctance_mode = ~reluctance_level;

   // Phase slices fed from working copies, the counter and the live reluctance mode
   assign phase_a_if.half_len = state.half_len_w;
   assign phase_a_if.count = state.count;
   assign phase_a_if.duty = state.duty_a_w;
   assign phase_a_if.dead_time = state.dead_w;
   assign phase_a_if.min_on_time = state.min_w;
   assign phase_a_if.second_half = state.second_half;
   assign phase_a_if.reluctance_mode = reluctance_mode;
   assign phase_b_if.half_len = state.half_len_w;
   assign phase_b_if.count = state.count;
   assign phase_b_if.duty = state.duty_b_w;
   assign phase_b_if.dead_time = state.dead_w;
   assign phase_b_if.min_on_time = state.min_w;
   assign phase_b_if.second_half = state.second_half;
   assign phase_b_if.reluctance_mode = reluctance_mode;
   assign phase_c_if.half_len = state.half_len_w;
   assign phase_c_if.count = state.count;
   assign phase_c_if.duty = state.duty_c_w;
   assign phase_c_if.dead_time = state.dead_w;
   assign phase_c_if.min_on_time = state.min_w;
   assign phase_c_if.second_half = state.second_half;
   assign phase_c_if.reluctance_mode = reluctance_mode;

   phase_timing slice_a (
      .pt(phase_a_if.slice)
   );
   phase_timing slice_b (
      .pt(phase_b_if.slice)
   );
   phase_timing slice_c (
      .pt(phase_c_if.slice)
   );

   assign timing_hi_n = {phase_a_if.hi_n, phase_b_if.hi_n, phase_c_if.hi_n};
   assign timing_lo_n = {phase_a_if.lo_n, phase_b_if.lo_n, phase_c_if.lo_n};

   // Bus handshake: request taken while waitrequest is low
   assign bus_req = avs_read | avs_write;
   assign bus_take = bus_req & ~state.waitrequest;

   // Period timing events
   assign at_half_end = state.running && (state.count == sat_sub(state.half_len_w, 16'h0001));
   assign latch_now = !state.running || (at_half_end && (state.second_half || state.double_w));

   // Crossover stage, then per-pin disable; a high, a low, b high, b low, c high, c low
   always_comb begin
      crossed[5] = state.steer_w[XOVER_A_BIT] ? timing_lo_n[2] : timing_hi_n[2];
      crossed[4] = state.steer_w[XOVER_A_BIT] ? timing_hi_n[2] : timing_lo_n[2];
      crossed[3] = state.steer_w[XOVER_B_BIT] ? timing_lo_n[1] : timing_hi_n[1];
      crossed[2] = state.steer_w[XOVER_B_BIT] ? timing_hi_n[1] : timing_lo_n[1];
      crossed[1] = state.steer_w[XOVER_C_BIT] ? timing_lo_n[0] : timing_hi_n[0];
      crossed[0] = state.steer_w[XOVER_C_BIT] ? timing_hi_n[0] : timing_lo_n[0];
      gated[5] = crossed[5] | state.steer_w[DIS_A_HIGH_BIT];
      gated[4] = crossed[4] | state.steer_w[DIS_A_LOW_BIT];
      gated[3] = crossed[3] | state.steer_w[DIS_B_HIGH_BIT];
      gated[2] = crossed[2] | state.steer_w[DIS_B_LOW_BIT];
      gated[1] = crossed[1] | state.steer_w[DIS_C_HIGH_BIT];
      gated[0] = crossed[0] | state.steer_w[DIS_C_LOW_BIT];
   end

   // Next-state: bus slave, counter, latching and output register
   always_comb begin
      next_state = state;
      next_state.sync_pulse = 1'b0;

      // Waitrequest drops for one cycle per request
      next_state.waitrequest = !(bus_req && state.waitrequest);
      if (bus_req && state.waitrequest) begin
         next_state.readdata = 32'h0000_0000;
         unique case (avs_address)
            OFS_CONTROL: next_state.readdata = {30'h0, state.control};
            OFS_HALF_PERIOD: next_state.readdata = {16'h0, state.half_period_count};
            OFS_DEAD_TIME: next_state.readdata = {22'h0, state.dead_time};
            OFS_DUTY_A: next_state.readdata = {16'h0, state.duty_phase_a};
            OFS_DUTY_B: next_state.readdata = {16'h0, state.duty_phase_b};
            OFS_DUTY_C: next_state.readdata = {16'h0, state.duty_phase_c};
            OFS_MIN_ON_TIME: next_state.readdata = {22'h0, state.min_on_time};
            OFS_OUTPUT_STEERING: next_state.readdata = {23'h0, state.output_steering};
            OFS_SYSTEM_STATUS: begin
               next_state.readdata[STAT_RELUCT_BIT] = reluctance_level;
               next_state.readdata[STAT_HALF_BIT] = state.second_half;
            end
            default: next_state.readdata = 32'h0000_0000;
         endcase
      end

      // Writes land at the edge where waitrequest is sampled low
      if (bus_take && avs_write) begin
         unique case (avs_address)
            OFS_CONTROL: next_state.control = avs_writedata[1:0];
            OFS_HALF_PERIOD: next_state.half_period_count = avs_writedata[COUNT_W-1:0];
            OFS_DEAD_TIME: next_state.dead_time = avs_writedata[DEAD_W-1:0];
            OFS_DUTY_A: next_state.duty_phase_a = avs_writedata[COUNT_W-1:0];
            OFS_DUTY_B: next_state.duty_phase_b = avs_writedata[COUNT_W-1:0];
            OFS_DUTY_C: next_state.duty_phase_c = avs_writedata[COUNT_W-1:0];
            OFS_MIN_ON_TIME: next_state.min_on_time = avs_writedata[MIN_W-1:0];
            OFS_OUTPUT_STEERING: next_state.output_steering = avs_writedata[STEER_W-1:0];
            default: next_state.control = state.control;
         endcase
      end

      // Half-period counter; runs only with a nonzero half length
      if (state.running) begin
         if (at_half_end) begin
            next_state.count = COUNT_RESET;
            next_state.second_half = ~state.second_half;
         end else begin
            next_state.count = state.count + 16'h0001;
         end
      end else begin
         next_state.count = COUNT_RESET;
         next_state.second_half = 1'b0;
      end

      // Working copies at period start, and midpoint when double
      if (latch_now) begin
         next_state.double_w = state.control[CTRL_DOUBLE_BIT];
         next_state.half_len_w = state.half_period_count;
         next_state.dead_w = state.dead_time;
         next_state.duty_a_w = state.duty_phase_a;
         next_state.duty_b_w = state.duty_phase_b;
         next_state.duty_c_w = state.duty_phase_c;
         next_state.min_w = state.min_on_time;
         next_state.steer_w = state.output_steering;
         next_state.running = state.control[CTRL_RUN_BIT] && (state.half_period_count != COUNT_RESET);
         next_state.sync_pulse = next_state.running;
      end

      // Registered pins; all off while stopped
      next_state.outs = next_state.running ? gated : 6'h3F;
      if (!state.running) begin
         next_state.outs = 6'h3F;
      end
   end

   // State register with reset defaults
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= '{
            control: CONTROL_RESET,
            half_period_count: COUNT_RESET,
            dead_time: DEAD_RESET,
            duty_phase_a: COUNT_RESET,
            duty_phase_b: COUNT_RESET,
            duty_phase_c: COUNT_RESET,
            min_on_time: MIN_RESET,
            output_steering: STEER_RESET,
            double_w: 1'b0,
            half_len_w: COUNT_RESET,
            dead_w: DEAD_RESET,
            duty_a_w: COUNT_RESET,
            duty_b_w: COUNT_RESET,
            duty_c_w: COUNT_RESET,
            min_w: MIN_RESET,
            steer_w: STEER_RESET,
            running: 1'b0,
            second_half: 1'b0,
            count: COUNT_RESET,
            readdata: 32'h0000_0000,
            waitrequest: 1'b1,
            outs: 6'h3F,
            sync_pulse: 1'b0
         };
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata = state.readdata;
   assign avs_waitrequest = state.waitrequest;
   assign out_a_high = state.outs[5];
   assign out_a_low = state.outs[4];
   assign out_b_high = state.outs[3];
   assign out_b_low = state.outs[2];
   assign out_c_high = state.outs[1];
   assign out_c_low = state.outs[0];
   assign period_sync_pulse = state.sync_pulse;
endmodule
`default_nettype wire

// ---- pwm_pulse_delete_output_ctrl_tb.sv ----
// Testbench for the PWM back end: steering, deletion, reluctance, update
// modes and registers. Assumes 40 MHz clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module pwm_pulse_delete_output_ctrl_tb;
   import pwm_out_pkg::*;
   localparam int HALF = 20;
   typedef struct packed {
      logic [15:0] da, db, dc;
      logic [9:0] dead, mn;
      logic [8:0] steer;
      logic rsel_n, dbl;
      logic [47:0] exp;
      logic [1:0] ns;
   } row_t;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [ADDR_W-1:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rsel_n = 1'b1;
   logic win = 1'b0;
   logic clr = 1'b0;
   wire logic [5:0] gate_n;
   wire logic sync;
   logic [7:0] cnt [6];
   logic [7:0] sync_cnt;
   logic [31:0] rd;
   int failures = 0;
   int comparisons = 0;
   // Inputs, then expected on-cycles per period {a_high, a_low, b_high, b_low, c_high, c_low} and syncs
   row_t rows [8] = '{
      '{16'h0005, 16'h000A, 16'h000F, 10'h000, 10'h000, 9'h000, 1'b1, 1'b0, 48'h0A1E14141E0A, 2'h1},
      '{16'h0005, 16'h000F, 16'h0007, 10'h003, 10'h004, 9'h000, 1'b1, 1'b0, 48'h002828000814, 2'h1},
      '{16'h0005, 16'h000A, 16'h000F, 10'h000, 10'h000, 9'h1C0, 1'b1, 1'b0, 48'h1E0A14140A1E, 2'h1},
      '{16'h0005, 16'h0005, 16'h000F, 10'h000, 10'h000, 9'h0A7, 1'b1, 1'b0, 48'h0A00000A0000, 2'h1},
      '{16'h0005, 16'h000A, 16'h000F, 10'h002, 10'h000, 9'h000, 1'b0, 1'b1, 48'h062810281A28, 2'h2},
      '{16'h0005, 16'h000A, 16'h000F, 10'h000, 10'h000, 9'h100, 1'b0, 1'b0, 48'h280A14281E28, 2'h1},
      '{16'h0005, 16'h000A, 16'h000F, 10'h000, 10'h000, 9'h03F, 1'b1, 1'b1, 48'h000000000000, 2'h2},
      '{16'h0014, 16'h0000, 16'h000A, 10'h000, 10'h000, 9'h015, 1'b1, 1'b0, 48'h000000280014, 2'h1}};

   always #12.5 clk = ~clk;

   pwm_pulse_delete_output_ctrl dut (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .reluctance_select_n(rsel_n), .out_a_high(gate_n[5]),
      .out_a_low(gate_n[4]), .out_b_high(gate_n[3]), .out_b_low(gate_n[2]), .out_c_high(gate_n[1]),
      .out_c_low(gate_n[0]), .period_sync_pulse(sync));
   gate_driver_model gdm (.clk, .window(win), .clear(clr), .gate_n, .sync_pulse(sync),
      .on_cnt(cnt), .sync_cnt);

   // Compare and report
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic timeout();
      check(32'h0, 32'h1);
      conclude();
   endtask
   // One Avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 50)
         timeout();
   endtask
   task automatic wait_sync(input int k);
      int n;
      n = 0;
      repeat (k) begin
         do begin
            @(posedge clk);
            n++;
         end while (sync !== 1'b1 && n < 400);
      end
      if (n >= 400)
         timeout();
   endtask
   // Count on-cycles over exactly one period
   task automatic measure();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      win <= 1'b1;
      repeat (2 * HALF) @(posedge clk);
      win <= 1'b0;
      @(posedge clk);
   endtask
   task automatic run_row(input row_t r);
      bus(1'b1, OFS_DUTY_A, {16'h0, r.da}, rd);
      bus(1'b1, OFS_DUTY_B, {16'h0, r.db}, rd);
      bus(1'b1, OFS_DUTY_C, {16'h0, r.dc}, rd);
      bus(1'b1, OFS_DEAD_TIME, {22'h0, r.dead}, rd);
      bus(1'b1, OFS_MIN_ON_TIME, {22'h0, r.mn}, rd);
      bus(1'b1, OFS_OUTPUT_STEERING, {23'h0, r.steer}, rd);
      bus(1'b1, OFS_CONTROL, {30'h0, r.dbl, 1'b1}, rd);
      rsel_n <= r.rsel_n;
      wait_sync(4);
      measure();
      for (int k = 0; k < 6; k++) begin
         check({24'h0, cnt[k]}, {24'h0, r.exp[8*k +: 8]});
      end
      check({24'h0, sync_cnt}, {30'h0, r.ns}); // Syncs per period
   endtask

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      bus(1'b1, OFS_HALF_PERIOD, 32'(HALF), rd);
      for (int i = 0; i < 8; i++) begin
         run_row(rows[i]);
         $display("row %0d done", i);
      end
      // Double update: duty alternates 6 and 5 between halves
      run_row('{16'h0005, 16'h000A, 16'h000F, 10'h000, 10'h000, 9'h000, 1'b1, 1'b1, 48'h0A1E14141E0A, 2'h2});
      fork
         repeat (8) begin
            wait_sync(1);
            bus(1'b0, OFS_SYSTEM_STATUS, 32'h0, rd);
            bus(1'b1, OFS_DUTY_A, rd[STAT_HALF_BIT] ? 32'h5 : 32'h6, rd);
         end
         begin
            repeat (100) @(posedge clk);
            measure();
         end
      join
      check({24'h0, cnt[5]}, 32'hB); // Odd on-time
      check({24'h0, cnt[4]}, 32'h1D); // Complement
      $display("double update done");
      bus(1'b1, OFS_MIN_ON_TIME, 32'hFFFFFFFF, rd);
      bus(1'b0, OFS_MIN_ON_TIME, 32'h0, rd);
      check(rd, 32'h3FF); // Ten-bit field
      bus(1'b1, OFS_OUTPUT_STEERING, 32'hFFFFFFFF, rd);
      bus(1'b0, OFS_OUTPUT_STEERING, 32'h0, rd);
      check(rd, 32'h1FF); // Nine-bit field
      rsel_n <= 1'b0;
      repeat (10) @(posedge clk);
      bus(1'b1, OFS_SYSTEM_STATUS, 32'h10, rd);
      bus(1'b0, OFS_SYSTEM_STATUS, 32'h0, rd);
      check({31'h0, rd[STAT_RELUCT_BIT]}, 32'h0); // Pin low seen
      rsel_n <= 1'b1;
      repeat (10) @(posedge clk);
      bus(1'b0, OFS_SYSTEM_STATUS, 32'h0, rd);
      check({31'h0, rd[STAT_RELUCT_BIT]}, 32'h1); // Pin high, mode off
      bus(1'b0, 6'h24, 32'h0, rd);
      check(rd, 32'h0); // Unmapped reads zero
      $display("register tests done");
      srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      bus(1'b0, OFS_OUTPUT_STEERING, 32'h0, rd);
      check(rd, 32'h0); // Steering cleared
      bus(1'b0, OFS_MIN_ON_TIME, 32'h0, rd);
      check(rd, 32'h0); // Minimum cleared
      $display("reset test done");
      conclude();
   end
endmodule
`default_nettype wire
